/* File: shared/spl_pkg.sv */
// constants and register map for the shared pin port pair
package spl_pkg;
  localparam int unsigned L_W = 8;
  localparam int unsigned M_W = 4;
  localparam int unsigned M_LSB = 2;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SYNC_W = L_W + M_W;

  localparam logic [ADDR_W-1:0] OFF_L_OUT = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_L_IN = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_L_DIR = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_L_RDR = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_L_PER = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_L_PPS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_M_OUT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_M_IN = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_M_DIR = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_M_RDR = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_M_PER = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_M_OD = 12'h02c;

  localparam logic [L_W-1:0] RST_L_OUT = 8'h00;
  localparam logic [L_W-1:0] RST_L_DIR = 8'h00;
  localparam logic [L_W-1:0] RST_L_RDR = 8'h00;
  localparam logic [L_W-1:0] RST_L_PER = 8'hff;
  localparam logic [L_W-1:0] RST_L_PPS = 8'hff;
  localparam logic [M_W-1:0] RST_M_ZERO = 4'h0;
  localparam logic [L_W-1:0] L_ALL_ONES = 8'hff;

  // port m bit positions inside the 4-bit slice (pin 5:2 -> index 3:0)
  localparam int unsigned M_NET0_TX = 0;
  localparam int unsigned M_NET0_RX = 1;
  localparam int unsigned M_NET1_TX = 2;
  localparam int unsigned M_NET1_RX = 3;
endpackage

/* File: shared/spl_sync_if.sv */
// carrier between the core and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface spl_sync_if;
  logic [spl_pkg::SYNC_W-1:0] raw;
  logic [spl_pkg::SYNC_W-1:0] sync;
  modport user   (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface
`default_nettype wire

/* File: hw/spl_sync.sv */
// two-stage synchroniser bank for pin levels
`timescale 1ns/1ps
`default_nettype none
module spl_sync (
  input  wire logic   sys_clk,
  input  wire logic   srst,
  spl_sync_if.syncer  bus
);
  typedef struct packed {
    logic [spl_pkg::SYNC_W-1:0] meta;
    logic [spl_pkg::SYNC_W-1:0] stable;
  } spl_sync_st_t;

  spl_sync_st_t st_reg;
  spl_sync_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.meta = bus.raw;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.sync = st_reg.stable;
endmodule
`default_nettype wire

/* File: hw/spl_port_pair.sv */
// shared pin port pair: 8-bit port l and 4-bit port m with apb registers
//
// Contract
// [R1] port l output pin level follows stored data when direction is output
// [R2] writes to port l data always store, pin unchanged while input
// [R3] port l data read returns stored bit for output pins
// [R4] port l input pin with converter digital input off reads 1
// [R5] port l input pin owned by display frontplane reads 1
// [R6] port l input pin, digital on, no frontplane, reads pin level
// [R7] port l input register reads 1 if frontplane or digital off, else pin
// [R8] input registers are read only, writes ignored without side effect
// [R9] port l direction bit 0 input, 1 output
// [R10] enabled frontplane driver owns the pin, direction bit ignored
// [R11] reduced drive bit 0 full strength, 1 about third strength
// [R12] reduced drive bit has no effect on input pins
// [R13] port l pull enable acts only on input pins
// [R14] port l pull select 0 up, 1 down, only when input and enabled
// [R15] port m bits 5:4 go to network one, 3:2 to network zero
// [R16] enabled network forces transmit output and receive input
// [R17] during reset all port m pins are high impedance inputs
// [R18] port m data read returns stored bit for outputs, pin for inputs
// [R19] port m input register always returns the pin level
// [R20] port m direction implements bits 5:2 only
// [R21] port m pull enable acts on inputs and open drain outputs
// [R22] during reset port l pins are inputs with pull down
// [R23] port m open drain output only drives low, ignored for inputs
// [R24] pin levels pass two flip-flops before the read path
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spl_port_pair #(
  parameter int unsigned L_WIDTH = spl_pkg::L_W,
  parameter int unsigned M_WIDTH = spl_pkg::M_W
) (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [spl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [spl_pkg::L_W-1:0]     pl_in,
  output logic      [spl_pkg::L_W-1:0]     pl_out,
  output logic      [spl_pkg::L_W-1:0]     pl_oe,
  output logic      [spl_pkg::L_W-1:0]     pl_reduced,
  output logic      [spl_pkg::L_W-1:0]     pl_pull_en,
  output logic      [spl_pkg::L_W-1:0]     pl_pull_down,
  output logic      [spl_pkg::L_W-1:0]     pl_frontplane_sel,
  input  wire logic                        display_enable,
  input  wire logic [spl_pkg::L_W-1:0]     frontplane_enable,
  input  wire logic [spl_pkg::L_W-1:0]     converter_digital_input_enable,
  input  wire logic [spl_pkg::M_W-1:0]     pm_in,
  output logic      [spl_pkg::M_W-1:0]     pm_out,
  output logic      [spl_pkg::M_W-1:0]     pm_oe,
  output logic      [spl_pkg::M_W-1:0]     pm_reduced,
  output logic      [spl_pkg::M_W-1:0]     pm_pull_en,
  input  wire logic                        network_zero_enable,
  input  wire logic                        network_zero_transmit_pin,
  output logic                             network_zero_receive_pin,
  input  wire logic                        network_one_enable,
  input  wire logic                        network_one_transmit_pin,
  output logic                             network_one_receive_pin
);
  if (L_WIDTH != spl_pkg::L_W || M_WIDTH != spl_pkg::M_W) begin : g_bad_width
    $error("spl_port_pair: port widths are fixed by the register map");
  end

  typedef logic [spl_pkg::L_W-1:0] spl_l_t;
  typedef logic [spl_pkg::M_W-1:0] spl_m_t;

  typedef struct packed {
    spl_l_t      l_out;
    spl_l_t      l_dir;
    spl_l_t      l_rdr;
    spl_l_t      l_per;
    spl_l_t      l_pps;
    spl_m_t      m_out;
    spl_m_t      m_dir;
    spl_m_t      m_rdr;
    spl_m_t      m_per;
    spl_m_t      m_od;
    logic [31:0] rdata;
  } spl_core_st_t;

  spl_core_st_t st_reg;
  spl_core_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  spl_sync_if sync_bus ();

  assign sync_bus.raw = {pm_in, pl_in};

  spl_sync u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .bus     (sync_bus.syncer)
  );

  spl_l_t l_pin;
  spl_m_t m_pin;

  assign l_pin = sync_bus.sync[spl_pkg::L_W-1:0]; // R24
  assign m_pin = sync_bus.sync[spl_pkg::SYNC_W-1:spl_pkg::L_W]; // R24

  ////////////////////////////////////////////////////////////////////////////
  // port l pin control

  spl_l_t l_fp_own;
  spl_l_t l_gpio_out;
  spl_l_t l_gpio_in;
  spl_l_t l_rd_out;
  spl_l_t l_rd_in;

  assign l_fp_own = frontplane_enable & {spl_pkg::L_W{display_enable}}; // R10
  assign l_gpio_out = st_reg.l_dir & ~l_fp_own; // R9 R10
  assign l_gpio_in = ~st_reg.l_dir & ~l_fp_own; // R9 R10

  always_comb begin
    if (srst) begin
      pl_out = '0;
      pl_oe = '0; // R22
      pl_reduced = '0;
      pl_pull_en = spl_pkg::L_ALL_ONES; // R22
      pl_pull_down = spl_pkg::L_ALL_ONES; // R22
    end else begin
      pl_out = st_reg.l_out & l_gpio_out; // R1 R2
      pl_oe = l_gpio_out; // R1 R2
      pl_reduced = st_reg.l_rdr & l_gpio_out; // R11 R12
      pl_pull_en = st_reg.l_per & l_gpio_in; // R13
      pl_pull_down = st_reg.l_pps & st_reg.l_per & l_gpio_in; // R14
    end
  end

  assign pl_frontplane_sel = l_fp_own; // R10

  // read values for the data and input registers
  always_comb begin
    for (int i = 0; i < spl_pkg::L_W; i++) begin
      if (st_reg.l_dir[i]) begin
        l_rd_out[i] = st_reg.l_out[i]; // R3
      end else if (!converter_digital_input_enable[i]) begin
        l_rd_out[i] = 1'b1; // R4
      end else if (l_fp_own[i]) begin
        l_rd_out[i] = 1'b1; // R5
      end else begin
        l_rd_out[i] = l_pin[i]; // R6
      end
      if (l_fp_own[i] || !converter_digital_input_enable[i]) begin
        l_rd_in[i] = 1'b1; // R7
      end else begin
        l_rd_in[i] = l_pin[i]; // R7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port m pin control

  spl_m_t m_force_out;
  spl_m_t m_force_in;
  spl_m_t m_dir_eff;
  spl_m_t m_data_eff;
  spl_m_t m_od_eff;

  always_comb begin
    m_force_out = '0;
    m_force_in = '0;
    m_force_out[spl_pkg::M_NET0_TX] = network_zero_enable; // R15 R16
    m_force_in[spl_pkg::M_NET0_RX] = network_zero_enable; // R15 R16
    m_force_out[spl_pkg::M_NET1_TX] = network_one_enable; // R15 R16
    m_force_in[spl_pkg::M_NET1_RX] = network_one_enable; // R15 R16
  end

  assign m_dir_eff = (st_reg.m_dir | m_force_out) & ~m_force_in; // R16 R20

  always_comb begin
    m_data_eff = st_reg.m_out;
    if (network_zero_enable) begin
      m_data_eff[spl_pkg::M_NET0_TX] = network_zero_transmit_pin; // R15
    end
    if (network_one_enable) begin
      m_data_eff[spl_pkg::M_NET1_TX] = network_one_transmit_pin; // R15
    end
  end

  assign m_od_eff = st_reg.m_od & m_dir_eff; // R23

  always_comb begin
    if (srst) begin
      pm_out = '0;
      pm_oe = '0; // R17
      pm_reduced = '0;
      pm_pull_en = '0; // R17
    end else begin
      pm_out = m_data_eff & ~m_od_eff; // R23
      // open drain only enables the driver while the level is low
      pm_oe = m_dir_eff & ~(m_od_eff & m_data_eff); // R23
      pm_reduced = st_reg.m_rdr & m_dir_eff; // R11 R12
      pm_pull_en = st_reg.m_per & (~m_dir_eff | m_od_eff); // R21
    end
  end

  assign network_zero_receive_pin = m_pin[spl_pkg::M_NET0_RX]; // R15
  assign network_one_receive_pin = m_pin[spl_pkg::M_NET1_RX]; // R15

  spl_m_t m_rd_out;

  assign m_rd_out = (st_reg.m_dir & st_reg.m_out) | (~st_reg.m_dir & m_pin); // R18

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic do_write;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;

  always_comb begin
    case (paddr)
      spl_pkg::OFF_L_OUT,
      spl_pkg::OFF_L_IN,
      spl_pkg::OFF_L_DIR,
      spl_pkg::OFF_L_RDR,
      spl_pkg::OFF_L_PER,
      spl_pkg::OFF_L_PPS,
      spl_pkg::OFF_M_OUT,
      spl_pkg::OFF_M_IN,
      spl_pkg::OFF_M_DIR,
      spl_pkg::OFF_M_RDR,
      spl_pkg::OFF_M_PER,
      spl_pkg::OFF_M_OD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign do_write = access_ph & pwrite & mapped;

  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (paddr)
      spl_pkg::OFF_L_OUT: rd_word[spl_pkg::L_W-1:0] = l_rd_out;
      spl_pkg::OFF_L_IN:  rd_word[spl_pkg::L_W-1:0] = l_rd_in;
      spl_pkg::OFF_L_DIR: rd_word[spl_pkg::L_W-1:0] = st_reg.l_dir;
      spl_pkg::OFF_L_RDR: rd_word[spl_pkg::L_W-1:0] = st_reg.l_rdr;
      spl_pkg::OFF_L_PER: rd_word[spl_pkg::L_W-1:0] = st_reg.l_per;
      spl_pkg::OFF_L_PPS: rd_word[spl_pkg::L_W-1:0] = st_reg.l_pps;
      spl_pkg::OFF_M_OUT: rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = m_rd_out;
      spl_pkg::OFF_M_IN:  rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = m_pin; // R19
      spl_pkg::OFF_M_DIR: rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = st_reg.m_dir; // R20
      spl_pkg::OFF_M_RDR: rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = st_reg.m_rdr;
      spl_pkg::OFF_M_PER: rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = st_reg.m_per;
      spl_pkg::OFF_M_OD:  rd_word[spl_pkg::M_LSB +: spl_pkg::M_W] = st_reg.m_od;
      default:            rd_word = '0;
    endcase
  end

  spl_l_t wl;
  spl_m_t wm;

  assign wl = pwdata[spl_pkg::L_W-1:0];
  assign wm = pwdata[spl_pkg::M_LSB +: spl_pkg::M_W];

  always_comb begin
    st_next = st_reg;
    // read data is captured in the setup cycle so it is stable in access
    if (setup_ph && !pwrite) begin
      st_next.rdata = rd_word;
    end
    if (do_write) begin
      case (paddr)
        spl_pkg::OFF_L_OUT: st_next.l_out = wl; // R1 R2
        spl_pkg::OFF_L_DIR: st_next.l_dir = wl; // R9
        spl_pkg::OFF_L_RDR: st_next.l_rdr = wl;
        spl_pkg::OFF_L_PER: st_next.l_per = wl;
        spl_pkg::OFF_L_PPS: st_next.l_pps = wl;
        spl_pkg::OFF_M_OUT: st_next.m_out = wm;
        spl_pkg::OFF_M_DIR: st_next.m_dir = wm; // R20
        spl_pkg::OFF_M_RDR: st_next.m_rdr = wm;
        spl_pkg::OFF_M_PER: st_next.m_per = wm;
        spl_pkg::OFF_M_OD:  st_next.m_od = wm;
        default:            st_next = st_reg; // R8
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg.l_out <= spl_pkg::RST_L_OUT;
      st_reg.l_dir <= spl_pkg::RST_L_DIR; // R22
      st_reg.l_rdr <= spl_pkg::RST_L_RDR;
      st_reg.l_per <= spl_pkg::RST_L_PER; // R22
      st_reg.l_pps <= spl_pkg::RST_L_PPS; // R22
      st_reg.m_out <= spl_pkg::RST_M_ZERO;
      st_reg.m_dir <= spl_pkg::RST_M_ZERO; // R17
      st_reg.m_rdr <= spl_pkg::RST_M_ZERO;
      st_reg.m_per <= spl_pkg::RST_M_ZERO; // R17
      st_reg.m_od <= spl_pkg::RST_M_ZERO;
      st_reg.rdata <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
endmodule
`default_nettype wire

/* File: tb/spl_pin_model.sv */
// pad model: pulls, floating lines and external drivers on both ports
`timescale 1ns/1ps
`default_nettype none
module spl_pin_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pl_out,
  input  wire logic [7:0] pl_oe,
  input  wire logic [7:0] pl_pull_en,
  input  wire logic [7:0] pl_pull_down,
  input  wire logic [7:0] ext_l_en,
  input  wire logic [7:0] ext_l,
  input  wire logic [3:0] pm_out,
  input  wire logic [3:0] pm_oe,
  input  wire logic [3:0] pm_pull_en,
  input  wire logic [3:0] ext_m_en,
  input  wire logic [3:0] ext_m,
  output logic      [7:0] pl_in,
  output logic      [3:0] pm_in
);
  // an undriven, unpulled line wanders every cycle
  logic flt = 1'b0;
  always @(posedge sys_clk) begin
    flt <= ~flt;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pl_in[i] = pl_oe[i] ? pl_out[i] : ext_l_en[i] ? ext_l[i] :
                 pl_pull_en[i] ? !pl_pull_down[i] : flt;
    end
    // port m pulls are pull-up only
    for (int i = 0; i < 4; i++) begin
      pm_in[i] = pm_oe[i] ? pm_out[i] : ext_m_en[i] ? ext_m[i] : pm_pull_en[i] ? 1'b1 : flt;
    end
  end
endmodule
`default_nettype wire

/* File: tb/spl_port_pair_assertions.sv */
// concurrent checks on the port pair pins and read path
`timescale 1ns/1ps
`default_nettype none
module spl_port_pair_assertions (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  pl_oe,
  input wire logic [7:0]  pl_reduced,
  input wire logic [7:0]  pl_pull_en,
  input wire logic [7:0]  pl_pull_down,
  input wire logic [7:0]  pl_frontplane_sel,
  input wire logic        display_enable,
  input wire logic [7:0]  frontplane_enable,
  input wire logic [3:0]  pm_in,
  input wire logic [3:0]  pm_out,
  input wire logic [3:0]  pm_oe,
  input wire logic [3:0]  pm_reduced,
  input wire logic [3:0]  pm_pull_en,
  input wire logic        network_zero_enable,
  input wire logic        network_zero_transmit_pin,
  input wire logic        network_zero_receive_pin,
  input wire logic        network_one_enable,
  input wire logic        network_one_transmit_pin,
  input wire logic        network_one_receive_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_fp_sel;
    pl_frontplane_sel == (frontplane_enable & {8{display_enable}});
  endproperty
  a_fp_sel: assert property (p_fp_sel) else $error("frontplane select wrong");
  property p_l_rst;
    disable iff (1'b0) srst |-> pl_oe == 8'h00 && pl_pull_en == 8'hff && pl_pull_down == 8'hff;
  endproperty
  a_l_rst: assert property (p_l_rst) else $error("port l reset pins wrong");
  property p_m_rst;
    disable iff (1'b0) srst |-> pm_oe == 4'h0 && pm_pull_en == 4'h0;
  endproperty
  a_m_rst: assert property (p_m_rst) else $error("port m reset pins wrong");
  property p_reduced;
    // a released open-drain output is still an output, so port m checks forced inputs
    (pl_reduced & ~pl_oe) == 8'h00 && !(network_zero_enable && pm_reduced[1]) &&
      !(network_one_enable && pm_reduced[3]);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced drive on input");
  property p_pull_l;
    (pl_pull_en & pl_oe) == 8'h00;
  endproperty
  a_pull_l: assert property (p_pull_l) else $error("pull on driven pin");
  property p_net0;
    network_zero_enable |-> !pm_oe[1] &&
      (pm_oe[0] ? pm_out[0] == network_zero_transmit_pin : network_zero_transmit_pin);
  endproperty
  a_net0: assert property (p_net0) else $error("network zero pins wrong");
  property p_net1;
    network_one_enable |-> !pm_oe[3] &&
      (pm_oe[2] ? pm_out[2] == network_one_transmit_pin : network_one_transmit_pin);
  endproperty
  a_net1: assert property (p_net1) else $error("network one pins wrong");
  property p_rx;
    !$past(srst) && !$past(srst, 2) |-> network_zero_receive_pin == $past(pm_in[1], 2)
      && network_one_receive_pin == $past(pm_in[3], 2);
  endproperty
  a_rx: assert property (p_rx) else $error("receive pin lag wrong");
  property p_rd_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  c_write: cover property (psel && penable && pwrite);
  c_fp: cover property (pl_frontplane_sel != 8'h00);
  c_net: cover property (network_zero_enable && network_one_enable);
  c_err: cover property (pslverr);
endmodule
bind spl_port_pair spl_port_pair_assertions u_chk (.sys_clk, .srst, .psel, .penable, .pwrite,
  .prdata, .pslverr, .pl_oe, .pl_reduced, .pl_pull_en, .pl_pull_down, .pl_frontplane_sel,
  .display_enable, .frontplane_enable, .pm_in, .pm_out, .pm_oe, .pm_reduced, .pm_pull_en,
  .network_zero_enable, .network_zero_transmit_pin, .network_zero_receive_pin,
  .network_one_enable, .network_one_transmit_pin, .network_one_receive_pin);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the shared pin port pair
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, display_enable = 1'b0;
  logic [7:0] pl_in, pl_out, pl_oe, pl_reduced, pl_pull_en, pl_pull_down, pl_frontplane_sel;
  logic [7:0] frontplane_enable = 8'h00, converter_digital_input_enable = 8'h00;
  logic [7:0] ext_l_en = 8'h00, ext_l = 8'h00;
  logic [3:0] pm_in, pm_out, pm_oe, pm_reduced, pm_pull_en, ext_m_en = 4'h0, ext_m = 4'h0;
  logic network_zero_enable = 1'b0, network_zero_transmit_pin = 1'b0, network_zero_receive_pin;
  logic network_one_enable = 1'b0, network_one_transmit_pin = 1'b0, network_one_receive_pin;
  int err_count = 0, tests_run = 0;
  typedef struct packed { logic [11:0] a; logic [31:0] d; logic [31:0] e; } spl_row_t;
  spl_row_t rows [10] = '{
    '{spl_pkg::OFF_L_DIR, 32'h0000_01a5, 32'h0000_00a5}, '{spl_pkg::OFF_L_RDR, 32'hffff_ffff,
    32'h0000_00ff}, '{spl_pkg::OFF_L_PER, 32'h0000_0000, 32'h0000_0000}, '{spl_pkg::OFF_L_PPS,
    32'h0000_005a, 32'h0000_005a}, '{spl_pkg::OFF_M_DIR, 32'hffff_ffff, 32'h0000_003c},
    '{spl_pkg::OFF_M_RDR, 32'h0000_0003, 32'h0000_0000}, '{spl_pkg::OFF_M_PER, 32'h0000_0024,
    32'h0000_0024}, '{spl_pkg::OFF_M_OD, 32'h0000_0018, 32'h0000_0018}, '{spl_pkg::OFF_L_OUT,
    32'h0000_00c3, 32'h0000_00db}, '{spl_pkg::OFF_M_OUT, 32'h0000_003c, 32'h0000_003c}};
  spl_port_pair uut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pl_in, .pl_out, .pl_oe, .pl_reduced, .pl_pull_en, .pl_pull_down,
    .pl_frontplane_sel, .display_enable, .frontplane_enable, .converter_digital_input_enable,
    .pm_in, .pm_out, .pm_oe, .pm_reduced, .pm_pull_en, .network_zero_enable,
    .network_zero_transmit_pin, .network_zero_receive_pin, .network_one_enable,
    .network_one_transmit_pin, .network_one_receive_pin);
  spl_pin_model u_pins (.sys_clk, .pl_out, .pl_oe, .pl_pull_en, .pl_pull_down, .ext_l_en,
    .ext_l, .pm_out, .pm_oe, .pm_pull_en, .ext_m_en, .ext_m, .pl_in, .pm_in);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    srst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rchk(spl_pkg::OFF_L_OUT, 32'h0000_00ff);
    rchk(spl_pkg::OFF_L_PER, 32'h0000_00ff);
    rchk(spl_pkg::OFF_L_PPS, 32'h0000_00ff);
    rchk(spl_pkg::OFF_M_DIR, 32'h0000_0000);
    {converter_digital_input_enable, ext_l_en, ext_l} <= {16'hffff, 8'h5a};
    repeat (3) @(posedge sys_clk);
    rchk(spl_pkg::OFF_L_OUT, 32'h0000_005a);
    rchk(spl_pkg::OFF_L_IN, 32'h0000_005a);
    {display_enable, frontplane_enable} <= {1'b1, 8'h0f};
    rchk(spl_pkg::OFF_L_OUT, 32'h0000_005f);
    chk({24'h00_0000, pl_frontplane_sel}, 32'h0000_000f);
    apb(1'b1, spl_pkg::OFF_L_IN, 32'h0000_00ff);
    rchk(spl_pkg::OFF_L_IN, 32'h0000_005f);
    rchk(spl_pkg::OFF_L_DIR, 32'h0000_0000);
    apb(1'b1, spl_pkg::OFF_M_IN, 32'hffff_ffff);
    rchk(spl_pkg::OFF_M_DIR, 32'h0000_0000);
    {display_enable, ext_l_en} <= {1'b0, 8'h00};
    apb(1'b1, spl_pkg::OFF_L_OUT, 32'h0000_0033);
    rchk(spl_pkg::OFF_L_OUT, 32'h0000_0000);
    apb(1'b1, spl_pkg::OFF_L_RDR, 32'h0000_0081);
    apb(1'b1, spl_pkg::OFF_L_DIR, 32'h0000_00ff);
    @(negedge sys_clk);
    chk({pl_oe, pl_out, pl_reduced, pl_pull_en}, 32'hff33_8100);
    rchk(spl_pkg::OFF_L_OUT, 32'h0000_0033);
    apb(1'b1, spl_pkg::OFF_L_DIR, 32'h0000_0000);
    apb(1'b1, spl_pkg::OFF_L_PPS, 32'h0000_003c);
    apb(1'b1, spl_pkg::OFF_L_PER, 32'h0000_00f0);
    @(negedge sys_clk);
    chk({pl_reduced, pl_pull_en, pl_pull_down, 8'h00}, 32'h00f0_3000);
    @(posedge sys_clk);
    {ext_m_en, ext_m} <= 8'hda;
    apb(1'b1, spl_pkg::OFF_M_RDR, 32'h0000_003c);
    apb(1'b1, spl_pkg::OFF_M_DIR, 32'h0000_000c);
    apb(1'b1, spl_pkg::OFF_M_OD, 32'h0000_0004);
    apb(1'b1, spl_pkg::OFF_M_OUT, 32'h0000_0004);
    apb(1'b1, spl_pkg::OFF_M_PER, 32'h0000_003c);
    repeat (3) @(posedge sys_clk);
    rchk(spl_pkg::OFF_M_OUT, 32'h0000_0024);
    rchk(spl_pkg::OFF_M_IN, 32'h0000_0020);
    chk({20'h0_0000, pm_reduced, pm_oe, pm_pull_en}, 32'h0000_032d);
    {ext_m_en, network_zero_enable, network_one_enable} <= 6'b1001_11;
    {network_zero_transmit_pin, network_one_transmit_pin} <= 2'b01;
    repeat (3) @(posedge sys_clk);
    chk({pm_oe, pm_out & pm_oe, 6'h00, network_one_receive_pin, network_zero_receive_pin},
        32'h0000_5403);
    {network_zero_enable, network_one_enable} <= 2'b00;
    @(negedge sys_clk);
    chk({28'h000_0000, pm_oe}, 32'h0000_0002);
    apb(1'b1, 12'h030, 32'hffff_ffff);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk({er, rd[30:0]}, 32'h8000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
